// ### test/rtcsw_core_asserts.sv
// checker for the serial register access core, bound to its ports
// assumes one clock domain with an active-low asynchronous reset
`timescale 1ns/1ps
module rtcsw_core_asserts #(
  parameter int SEC_CYCLES       = 200,
  parameter int CORR_STEP_CYCLES = 2,
  parameter int FREQ_STEP_CYCLES = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link pins
  input wire logic chipSelect,
  input wire logic shiftClock,
  input wire logic serialDataOut,
  input wire logic serialDataOe,
  // status
  input wire logic intOutN,
  input wire logic powerOnFlag,
  input wire logic alarm1Mode,
  input wire logic freqOutEnable,
  input wire logic secondAlarmEnable,
  input wire logic correctionIntervalSelect
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence csIdle;
    !chipSelect [*5];
  endsequence
  oe_idle_a: assert property (
    csIdle |-> !serialDataOe
  ) else $error("line driven while idle");
  oe_rise_a: assert property (
    $rose(serialDataOe) |-> chipSelect && !$past(shiftClock)
  ) else $error("drive began off a fall");
  out_move_a: assert property (
    serialDataOe && $changed(serialDataOut) |-> !$past(shiftClock)
  ) else $error("data moved off a fall");
  flag_keep_a: assert property (
    !powerOnFlag |=> !powerOnFlag
  ) else $error("flag set again");
  int_quiet_a: assert property (
    !powerOnFlag && !freqOutEnable && !$past(powerOnFlag) && !$past(freqOutEnable) |-> intOutN
  ) else $error("pin active after clear");
  int_hold_a: assert property (
    powerOnFlag && !freqOutEnable && !$past(freqOutEnable, 2) && $changed(intOutN)
      |=> $stable(intOutN) [*8]
  ) else $error("second pulse too short");
  cfg_link_a: assert property (
    $changed({alarm1Mode, freqOutEnable, secondAlarmEnable, correctionIntervalSelect})
      |-> chipSelect && shiftClock
  ) else $error("config moved outside a write");
  cfg_read_a: assert property (
    serialDataOe && $past(serialDataOe)
      |-> $stable({alarm1Mode, secondAlarmEnable, correctionIntervalSelect})
  ) else $error("config moved during a read");
endmodule
bind rtcsw_core rtcsw_core_asserts #(
  .SEC_CYCLES(SEC_CYCLES),
  .CORR_STEP_CYCLES(CORR_STEP_CYCLES),
  .FREQ_STEP_CYCLES(FREQ_STEP_CYCLES)
) rtcsw_core_asserts_i (
  .clk(clk), .resetn(resetn), .chipSelect(chipSelect), .shiftClock(shiftClock),
  .serialDataOut(serialDataOut), .serialDataOe(serialDataOe), .intOutN(intOutN),
  .powerOnFlag(powerOnFlag), .alarm1Mode(alarm1Mode), .freqOutEnable(freqOutEnable),
  .secondAlarmEnable(secondAlarmEnable),
  .correctionIntervalSelect(correctionIntervalSelect)
);

// ### test/rtcsw_core_test.sv
// self-checking bench for the serial register access core
// assumes the host model owns the link pins; second counts are shortened
`timescale 1ns/1ps
module rtcsw_core_test;
  import rtcsw_pkg::*;
  localparam int SECS = 200;
  localparam int STEP = 2;
  logic        clk    = 1'b0;
  logic        resetn = 1'b0;
  logic        chipSelect, shiftClock, serialDataIn, serialDataOut, serialDataOe;
  logic        intOutN, powerOnFlag, alarm1Mode, freqOutEnable, secondAlarmEnable, corrSel;
  logic [23:0] r;
  int          n_mismatch  = 0;
  int          checks_done = 0;
  always #10 clk = ~clk;
  rtcsw_core #(.SEC_CYCLES(SECS), .CORR_STEP_CYCLES(STEP), .FREQ_STEP_CYCLES(3)) rtcsw_core_i (
    .clk(clk), .resetn(resetn), .chipSelect(chipSelect), .shiftClock(shiftClock),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
    .intOutN(intOutN), .powerOnFlag(powerOnFlag), .alarm1Mode(alarm1Mode),
    .freqOutEnable(freqOutEnable), .secondAlarmEnable(secondAlarmEnable),
    .correctionIntervalSelect(corrSel));
  rtcsw_host rtcsw_host_i (.clk(clk), .chipSelect(chipSelect), .shiftClock(shiftClock),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d of %0d checks", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // code is group, select and direction; bytes go lowest first
  task automatic xfer(input logic [3:0] code, input int nb, input logic [23:0] wd);
    logic [7:0] b;
    r = 24'h0;
    rtcsw_host_i.sel(1'b1);
    rtcsw_host_i.shift({CMD_FIXED, code}, 1'b1, 1'b1, 8, b);
    for (int i = 0; i < nb; i++) begin
      rtcsw_host_i.shift(wd[8*i+:8], 1'b0, !code[0], 8, b);
      r[8*i+:8] = b;
    end
    rtcsw_host_i.sel(1'b0);
  endtask
  task automatic t_power();
    chk(24'(powerOnFlag), 24'h1);
    repeat (SECS / 4) @(negedge clk);
    chk(24'(intOutN), 24'h0);
    repeat (SECS / 2) @(negedge clk);
    chk(24'(intOutN), 24'h1);
  endtask
  task automatic t_status();
    xfer(4'h2, 1, 24'h12);
    chk({20'h0, alarm1Mode, freqOutEnable, secondAlarmEnable, corrSel}, 24'h6);
    rtcsw_host_i.sel(1'b1);
    rtcsw_host_i.shift({CMD_FIXED, 4'h2}, 1'b1, 1'b1, 7, r[7:0]);
    rtcsw_host_i.sel(1'b0);
    // foreign fixed code: the whole transfer must leave status 2 alone
    rtcsw_host_i.sel(1'b1);
    rtcsw_host_i.shift(8'h52, 1'b1, 1'b1, 8, r[7:0]);
    rtcsw_host_i.shift(8'hFF, 1'b0, 1'b1, 8, r[7:0]);
    rtcsw_host_i.sel(1'b0);
    xfer(4'h3, 1, 24'h0);
    chk(r, 24'h12);
    xfer(4'h1, 1, 24'h0);
    chk(r, {16'h0, STAT1_RESET});
  endtask
  task automatic t_alarm();
    xfer(4'h2, 1, 24'h22);
    xfer(4'h8, 3, 24'hA5_5A3C);
    xfer(4'hA, 3, 24'h12_3456);
    xfer(4'h9, 3, 24'h0);
    chk(r, 24'hA5_5A3C);
    xfer(4'hB, 3, 24'h0);
    chk(r, 24'h12_3456);
    xfer(4'h2, 1, 24'h0);
    xfer(4'h9, 2, 24'h0);
    chk(r, 24'h3C);
    xfer(4'hB, 2, 24'h0);
    chk(r, 24'h56);
  endtask
  // real-time group 1 written in full, then read back at once; free byte too
  task automatic t_time();
    logic [7:0] b;
    for (int d = 0; d < 2; d++) begin
      rtcsw_host_i.sel(1'b1);
      rtcsw_host_i.shift({CMD_FIXED, 3'b010, d[0]}, 1'b1, 1'b1, 8, b);
      for (int i = 0; i < RT1_LEN; i++) begin
        rtcsw_host_i.shift(8'(8'h11 * (i + 1)), 1'b0, d == 0, 8, b);
        if (d == 1) chk(24'(b), 24'(8'h11 * (i + 1)));
      end
      rtcsw_host_i.sel(1'b0);
    end
    xfer(4'h7, 3, 24'h0);
    chk(r, 24'h77_6655);
    xfer(4'hE, 1, 24'h5A);
    xfer(4'hF, 1, 24'h0);
    chk(r, 24'h5A);
  endtask
  // clk cycles spanned by n whole periods of the signal on intOutN
  task automatic periods(input int n, input int exp);
    time t0;
    @(negedge intOutN);
    t0 = $time;
    repeat (n) @(negedge intOutN);
    chk(24'(($time - t0) / 20), 24'(exp));
  endtask
  task automatic t_corr();
    xfer(4'hC, 1, 24'h80);
    chk(24'(corrSel), 24'h0);
    periods(20, 20 * SECS - STEP);
    xfer(4'hC, 1, 24'h81);
    chk(24'(corrSel), 24'h1);
    periods(60, 60 * SECS - STEP);
  endtask
  task automatic t_clear();
    xfer(4'h0, 1, 24'h80);
    chk(24'(powerOnFlag), 24'h0);
    repeat (SECS) @(negedge clk);
    chk(24'(intOutN), 24'h1);
  endtask
  // user frequency: half period is (first alarm byte + 1) steps of 3 clk
  task automatic t_freq();
    xfer(4'h2, 1, 24'h10);
    xfer(4'h8, 1, 24'h04);
    periods(2, 2 * 2 * (4 + 1) * 3);
    xfer(4'hA, 1, 24'h09);
    periods(2, 2 * 2 * (4 + 1) * 3);
  endtask
  // a second power-on in mid-run restarts the flag and the 1 Hz output
  task automatic t_restart();
    resetn = 1'b0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    t_power();
  endtask
  initial begin
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    t_power();
    t_status();
    t_alarm();
    t_time();
    t_corr();
    t_clear();
    t_freq();
    t_restart();
    conclude();
  end
  // about 25000 cycles are expected; allow twice that
  initial begin
    #1_000_000;
    n_mismatch++;
    conclude();
  end
endmodule

// ### test/rtcsw_host.sv
// host model: master of the three-wire link
// assumes clk is the system clock; shift clock half period is four clk
`timescale 1ns/1ps
module rtcsw_host (
  // system clock
  input  wire logic clk,
  // link pins
  output logic      chipSelect,
  output logic      shiftClock,
  output logic      serialDataIn,
  input  wire logic serialDataOut,
  input  wire logic serialDataOe
);
  logic hostBit = 1'b0;
  logic hostEn  = 1'b0;
  logic junk    = 1'b0;
  // a released line toggles every cycle so no stale bit can pass
  always @(negedge clk) junk <= ~junk;
  assign serialDataIn = serialDataOe ? serialDataOut : hostEn ? hostBit : junk;
  initial begin
    chipSelect = 1'b0;
    shiftClock = 1'b1;
  end
  task automatic sel(input logic on);
    chipSelect = on;
    hostEn     = 1'b0;
    repeat (5) @(negedge clk);
  endtask
  // command bits go msb first, data bits lsb first
  task automatic shift(input logic [7:0] tx, input logic msb, input logic drv, input int n,
                       output logic [7:0] rx);
    rx = 8'h0;
    for (int i = 0; i < n; i++) begin
      shiftClock = 1'b0;
      hostEn     = drv;
      hostBit    = msb ? tx[7-i] : tx[i];
      repeat (4) @(negedge clk);
      shiftClock = 1'b1;
      rx[msb ? 7-i : i] = serialDataIn;
      repeat (4) @(negedge clk);
    end
  endtask
endmodule

// ### verilog/rtcsw_core.sv
// register access core of a calendar clock behind a three-wire serial link
// assumes cs, sck and the data line come from pins and are asynchronous to clk
`timescale 1ns/1ps
module rtcsw_core #(
  parameter int SEC_CYCLES       = rtcsw_pkg::SEC_CYCLES,
  parameter int CORR_STEP_CYCLES = rtcsw_pkg::CORR_STEP_CYCLES,
  parameter int FREQ_STEP_CYCLES = rtcsw_pkg::FREQ_STEP_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // serial link pins
  input  wire logic chipSelect,
  input  wire logic shiftClock,
  input  wire logic serialDataIn,
  output logic      serialDataOut,
  output logic      serialDataOe,
  // interrupt pin, active low
  output logic      intOutN,
  // status seen by the rest of the chip
  output logic      powerOnFlag,
  output logic      alarm1Mode,
  output logic      freqOutEnable,
  output logic      secondAlarmEnable,
  output logic      correctionIntervalSelect
);
  import rtcsw_pkg::*;

  // pin synchronisers
  logic [1:0] csSync;
  logic [1:0] sckSync;
  logic [1:0] sioSync;
  logic       sckPrev;
  logic       csOn;
  logic       sckRise;
  logic       sckFall;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      csSync  <= 2'b00;
      sckSync <= 2'b11;
      sioSync <= 2'b00;
      sckPrev <= 1'b1;
    end else begin
      csSync  <= {csSync[0], chipSelect};
      sckSync <= {sckSync[0], shiftClock};
      sioSync <= {sioSync[0], serialDataIn};
      sckPrev <= sckSync[1];
    end
  end

  assign csOn    = csSync[1];
  assign sckRise = csOn && sckSync[1] && !sckPrev;
  assign sckFall = csOn && !sckSync[1] && sckPrev;

  // register store and transfer state
  logic [7:0]   regs [REG_BYTES];
  rtcsw_state_e state;
  logic [7:0]   cmdShift;
  logic [2:0]   bitCnt;
  logic [2:0]   byteIdx;
  logic [7:0]   dataShift;
  logic [2:0]   cmdSel;
  logic [4:0]   base;
  logic [2:0]   len;
  logic [7:0]   nextCmd;
  logic         storeByte;

  assign nextCmd = {cmdShift[6:0], sioSync[1]};

  // map group and select bit to a byte window of the store
  always_comb begin
    base = 5'(IDX_FREE);
    len  = 3'(SINGLE_LEN);
    unique case (cmdSel[2:1])
      GRP_STATUS: begin
        base = cmdSel[0] ? 5'(IDX_STAT2) : 5'(IDX_STAT1);
      end
      GRP_REALTIME: begin
        base = cmdSel[0] ? 5'(IDX_RT2) : 5'(IDX_RT1);
        len  = cmdSel[0] ? 3'(RT2_LEN) : 3'(RT1_LEN);
      end
      GRP_ALARM: begin
        if (cmdSel[0]) begin
          base = 5'(IDX_INT2);
          len  = secondAlarmEnable ? 3'(ALARM_LEN) : 3'(SINGLE_LEN);
        end else begin
          base = 5'(IDX_INT1);
          len  = alarm1Mode ? 3'(ALARM_LEN) : 3'(SINGLE_LEN);
        end
      end
      GRP_CORR_FREE: begin
        base = cmdSel[0] ? 5'(IDX_FREE) : 5'(IDX_CORR);
      end
    endcase
  end

  assign storeByte = (state == ST_WRITE) && sckRise && (bitCnt == 3'd7) && (byteIdx < len);

  // command decode and bit/byte sequencing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state     <= ST_CMD;
      cmdShift  <= 8'h00;
      bitCnt    <= 3'd0;
      byteIdx   <= 3'd0;
      dataShift <= 8'h00;
      cmdSel    <= 3'd0;
    end else if (!csOn) begin
      state   <= ST_CMD;
      bitCnt  <= 3'd0;
      byteIdx <= 3'd0;
    end else if (sckRise) begin
      bitCnt <= bitCnt + 3'd1;
      unique case (state)
        ST_CMD: begin
          cmdShift <= nextCmd;
          if (bitCnt == 3'd7) begin
            cmdSel <= nextCmd[3:1];
            if (nextCmd[7:4] != CMD_FIXED) begin
              state <= ST_IGNORE;
            end else if (nextCmd[0]) begin
              state <= ST_READ;
            end else begin
              state <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          dataShift <= {sioSync[1], dataShift[7:1]};
          if (bitCnt == 3'd7 && byteIdx < len) begin
            byteIdx <= byteIdx + 3'd1;
          end
        end
        ST_READ, ST_IGNORE: begin
        end
      endcase
    end
  end

  // register store writes, including status 1 software reset
  logic [7:0] wrByte;
  logic [4:0] wrIdx;
  logic       softReset;

  assign wrByte    = {sioSync[1], dataShift[7:1]};
  assign wrIdx     = 5'(base + 5'(byteIdx));
  assign softReset = storeByte && (wrIdx == 5'(IDX_STAT1)) && wrByte[STAT1_RESET_BIT];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < REG_BYTES; i++) begin
        regs[i] <= (i == IDX_STAT1) ? STAT1_RESET : REG_RESET;
      end
    end else if (softReset) begin
      for (int i = 0; i < REG_BYTES; i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (storeByte) begin
      if (wrIdx == 5'(IDX_STAT1)) begin
        // power-on flag is read-only; reset bit never stored
        regs[IDX_STAT1] <= {1'b0, wrByte[6:1], regs[IDX_STAT1][STAT1_POC_BIT]};
      end else begin
        regs[wrIdx] <= wrByte;
      end
    end
  end

  // read data, least significant bit first, changed on falling edges
  logic [2:0] rdBit;
  logic [2:0] rdByte;
  logic [4:0] rdIdx;

  assign rdIdx = 5'(base + 5'(rdByte));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serialDataOut <= 1'b0;
      serialDataOe  <= 1'b0;
      rdBit         <= 3'd0;
      rdByte        <= 3'd0;
    end else if (!csOn || state != ST_READ) begin
      serialDataOut <= 1'b0;
      serialDataOe  <= 1'b0;
      rdBit         <= 3'd0;
      rdByte        <= 3'd0;
    end else if (sckFall) begin
      serialDataOe <= 1'b1;
      if (rdByte < len) begin
        serialDataOut <= regs[rdIdx][rdBit];
      end else begin
        serialDataOut <= 1'b0;
      end
      rdBit <= rdBit + 3'd1;
      if (rdBit == 3'd7 && rdByte < len) begin
        rdByte <= rdByte + 3'd1;
      end
    end
  end

  assign powerOnFlag              = regs[IDX_STAT1][STAT1_POC_BIT];
  assign alarm1Mode               = regs[IDX_STAT2][STAT2_ALARM1_BIT];
  assign freqOutEnable            = regs[IDX_STAT2][STAT2_FREQ_BIT];
  assign secondAlarmEnable        = regs[IDX_STAT2][STAT2_ALARM2_BIT];
  assign correctionIntervalSelect = regs[IDX_CORR][CORR_SEL_BIT];

  // one-second pulse with periodic correction of one period
  logic [31:0] secCnt;
  logic [31:0] secLen;
  logic [5:0]  pulseCnt;
  logic [5:0]  pulseLast;
  logic        corrPulse;
  logic [6:0]  corrCode;
  logic signed [31:0] corrAdj;

  // correction value sits bit-reversed in bits 7:1
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      corrCode[i] = regs[IDX_CORR][7 - i];
    end
  end

  assign corrAdj   = 32'(signed'(corrCode)) * 32'(CORR_STEP_CYCLES);
  assign pulseLast = correctionIntervalSelect ? 6'(CORR_LONG_PULSES - 1)
                                              : 6'(CORR_SHORT_PULSES - 1);
  assign corrPulse = (pulseCnt == pulseLast) && (corrCode != 7'd0);
  // crystal rate untouched: only this one period is stretched or cut
  assign secLen    = corrPulse ? 32'(32'(SEC_CYCLES) - 32'(corrAdj)) : 32'(SEC_CYCLES);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      secCnt   <= 32'd0;
      pulseCnt <= 6'd0;
    end else if (secCnt >= secLen - 32'd1) begin
      secCnt <= 32'd0;
      if (pulseCnt >= pulseLast) begin
        pulseCnt <= 6'd0;
      end else begin
        pulseCnt <= pulseCnt + 6'd1;
      end
    end else begin
      secCnt <= secCnt + 32'd1;
    end
  end

  // user frequency from the first alarm byte; second register has none
  logic [31:0] freqCnt;
  logic [31:0] freqHalf;
  logic        freqLevel;

  assign freqHalf = 32'({24'h0000_00, regs[IDX_INT1]} + 32'd1) * 32'(FREQ_STEP_CYCLES);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      freqCnt   <= 32'd0;
      freqLevel <= 1'b1;
    end else if (!freqOutEnable) begin
      freqCnt   <= 32'd0;
      freqLevel <= 1'b1;
    end else if (freqCnt >= freqHalf - 32'd1) begin
      freqCnt   <= 32'd0;
      freqLevel <= !freqLevel;
    end else begin
      freqCnt <= freqCnt + 32'd1;
    end
  end

  // pin: power-on 1 Hz wins, then frequency output while alarm1Mode is clear, else idle high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      intOutN <= 1'b1;
    end else if (powerOnFlag) begin
      intOutN <= (secCnt >= (secLen >> 1));
    end else if (freqOutEnable && !alarm1Mode) begin
      intOutN <= freqLevel;
    end else begin
      intOutN <= 1'b1;
    end
  end

endmodule

// ### verilog/rtcsw_pkg.sv
// constants for the three-wire calendar clock register access block
// assumes a 50 MHz system clock; all timing counts derive from it
package rtcsw_pkg;

  // command byte: fixed code in bits 7:4, group in 3:2, select in 1, direction in 0
  localparam logic [3:0] CMD_FIXED     = 4'h6;
  localparam logic [1:0] GRP_STATUS    = 2'b00;
  localparam logic [1:0] GRP_REALTIME  = 2'b01;
  localparam logic [1:0] GRP_ALARM     = 2'b10;
  localparam logic [1:0] GRP_CORR_FREE = 2'b11;

  // byte indices into the register store, and byte lengths
  localparam int IDX_STAT1  = 0;
  localparam int IDX_STAT2  = 1;
  localparam int IDX_RT1    = 2;
  localparam int RT1_LEN    = 7;
  localparam int IDX_RT2    = 6;
  localparam int RT2_LEN    = 3;
  localparam int IDX_INT1   = 9;
  localparam int IDX_INT2   = 12;
  localparam int ALARM_LEN  = 3;
  localparam int SINGLE_LEN = 1;
  localparam int IDX_CORR   = 15;
  localparam int IDX_FREE   = 16;
  localparam int REG_BYTES  = 17;

  // field positions
  localparam int STAT1_POC_BIT    = 0;
  localparam int STAT1_RESET_BIT  = 7;
  localparam int STAT2_ALARM1_BIT = 5;
  localparam int STAT2_FREQ_BIT   = 4;
  localparam int STAT2_ALARM2_BIT = 1;
  localparam int CORR_SEL_BIT     = 0;

  // reset values
  localparam logic [7:0] STAT1_RESET = 8'h01;
  localparam logic [7:0] REG_RESET   = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS    = 20;
  localparam int SEC_PERIOD_NS    = 1_000_000_000;
  localparam int SEC_CYCLES       = SEC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CORR_STEP_NS     = 61035;
  localparam int CORR_STEP_CYCLES = CORR_STEP_NS / CLK_PERIOD_NS;
  localparam int FREQ_STEP_NS     = 15259;
  localparam int FREQ_STEP_CYCLES = FREQ_STEP_NS / CLK_PERIOD_NS;
  localparam int CORR_SHORT_PULSES = 20;
  localparam int CORR_LONG_PULSES  = 60;

  typedef enum logic [1:0] {
    ST_CMD   = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10,
    ST_IGNORE = 2'b11
  } rtcsw_state_e;

endpackage
